// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic core_clk_in, nrst_in, wr_in, rd_in, step_in, irq_out, rd_seen;
	logic [7:0] addr_in;
	logic [31:0] wdata_in, rdata_out, w1, w2, w3, tv;
	logic [vpt_pkg::NCH-1:0] chan_in;
	logic [vpt_pkg::ANG_W-1:0] crank_angle_in;
	logic [15:0] engine_rpm_in;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	int errors, compares;

	vpt_pulse_timing dut_u (.core_clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
		.rdata_out, .chan_in, .crank_angle_in, .engine_rpm_in, .step_in, .irq_out);
	vpt_unit_model model_u (.core_clk_in, .chan_out(chan_in));

	initial
	begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end

	// ----
	// Shared tasks
	// ----
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		compares++;
		if (seen !== want)
		begin
			errors++;
			$display("mismatch at %0t: got %h want %h", $time, seen, want);
		end
	endtask

	task automatic print_verdict;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge core_clk_in);
		wr_in <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		@(posedge core_clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge core_clk_in);
		rd_in <= 1'b0;
	endtask

	task automatic step;
		@(posedge core_clk_in);
		step_in <= 1'b1;
		@(posedge core_clk_in);
		step_in <= 1'b0;
	endtask

	task automatic irq_is(input logic [31:0] want);
		@(negedge core_clk_in);
		check({31'h0, irq_out}, want);
	endtask

	// Read data stand only in the cycle after the strobe, so look exactly there.
	always @(posedge core_clk_in)
	begin
		if (rd_seen)
			check(rdata_out & msk_q.pop_front(), exp_q.pop_front());
		rd_seen <= rd_in;
	end

	// ----
	// Scenarios
	// ----
	initial
	begin
		{nrst_in, wr_in, rd_in, step_in} = '0;
		addr_in = 8'h00;
		wdata_in = 32'h0;
		crank_angle_in = 10'd5;
		engine_rpm_in = 16'd1000;
		errors = 0;
		compares = 0;
		void'($urandom(76));
		w1 = 32'd100 * (32'd1 + $urandom % 5);
		w2 = 32'd100 * (32'd1 + $urandom % 5);
		w3 = 32'd100 * (32'd3 + $urandom % 3);
		tv = $urandom;
		repeat (4) @(posedge core_clk_in);
		nrst_in <= 1'b1;
		rd(8'h00, 32'h0);
		rd(8'h48, 32'h0000000a);
		rd(8'h08, 32'h0);
		rd(8'h30, 32'h0);
		wr(8'h00, 32'h1);
		wr(8'h44, {6'h0, 10'd20, 6'h0, 10'd700});
		wr(8'h60, 32'h20);
		wr(8'h64, {6'h0, 10'd719, 6'h0, 10'd0});
		wr(8'h80, 32'h223);
		wr(8'h88, {6'h0, 10'd360, 16'h000a});
		wr(8'ha0, 32'h402);
		wr(8'ha8, {6'h0, 10'd360, 16'h000a});
		wr(8'hac, tv);
		model_u.hold(8'h12, w1);
		model_u.hold(8'h13, w2);
		model_u.hold(8'h12, 20);
		rd(8'h50, 32'h0);
		rd(8'h04, 32'h3, 32'hf);
		step();
		rd(8'h50, w1 / 100);
		rd(8'h70, w2 / 100);
		wr(8'h08, 32'hff);
		crank_angle_in <= 10'd100;
		model_u.hold(8'h13, 100);
		model_u.hold(8'h12, 200);
		model_u.hold(8'h13, 20);
		rd(8'h04, 32'h2, 32'hf);
		step();
		rd(8'h50, w1 / 100);
		rd(8'h50, w1 / 100);
		wr(8'h08, 32'hff);
		wr(8'h44, {6'h0, 10'd719, 16'h0});
		wr(8'h40, 32'hcc);
		wr(8'h60, 32'h130);
		model_u.hold(8'h12, 100);
		model_u.hold(8'h1a, 100);
		model_u.hold(8'h1b, 100);
		model_u.hold(8'h0b, 100);
		model_u.hold(8'h1b, 100);
		model_u.hold(8'h1a, w3);
		model_u.hold(8'h1b, 100);
		model_u.hold(8'h1a, 100);
		model_u.hold(8'h12, 100);
		model_u.hold(8'h13, 20);
		step();
		rd(8'h50, w3 / 100);
		rd(8'h70, 32'd3);
		wr(8'h08, 32'hff);
		wr(8'h0c, 32'h40);
		irq_is(32'h0);
		@(posedge core_clk_in);
		crank_angle_in <= 10'd350;
		@(posedge core_clk_in);
		crank_angle_in <= 10'd360;
		repeat (5) @(posedge core_clk_in);
		irq_is(32'h1);
		rd(8'h04, 32'hc0, 32'hc0);
		step();
		rd(8'h90, 32'hffffffff);
		rd(8'hb0, tv);
		rd(8'h94, 32'h1, 32'h1);
		wr(8'h08, 32'h40);
		irq_is(32'h0);
		wr(8'h00, 32'h0);
		wr(8'h08, 32'hff);
		model_u.hold(8'h12, 100);
		model_u.hold(8'h13, 20);
		rd(8'h04, 32'h0, 32'hf);
		repeat (4) @(posedge core_clk_in);
		print_verdict();
	end

	// The scenarios need well under ten thousand cycles.
	initial
	begin
		repeat (20000) @(posedge core_clk_in);
		errors++;
		print_verdict();
	end
endmodule
`default_nettype wire

// [vpt_pkg.sv]
package vpt_pkg;

	// ----------------------------------------------------------------
	// Sizes and time base
	// ----------------------------------------------------------------
	localparam int NSLOT = 4;
	localparam int NCH = 8;
	localparam int ANG_W = 10;
	localparam int CLK_PERIOD_NS = 10;
	localparam int RES_NS = 1000;
	localparam int US_CYCLES = (RES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int US_PER_MS = 1000;
	localparam logic [15:0] RPM_STOP = 16'h000a;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_IRQ_STAT = 8'h04;
	localparam logic [7:0] A_IRQ_CLR = 8'h08;
	localparam logic [7:0] A_IRQ_EN = 8'h0c;
	localparam logic [7:0] A_SLOT0 = 8'h40;
	localparam int SLOT_STRIDE = 32;
	localparam logic [7:0] O_CFG = 8'h00;
	localparam logic [7:0] O_SEG = 8'h04;
	localparam logic [7:0] O_TO = 8'h08;
	localparam logic [7:0] O_TOVAL = 8'h0c;
	localparam logic [7:0] O_RES = 8'h10;
	localparam logic [7:0] O_STAT = 8'h14;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_EN_BIT = 0;
	localparam int CFG_W = 12;
	localparam int SEG_LO_LSB = 0;
	localparam int SEG_HI_LSB = 16;
	localparam int TO_MS_LSB = 0;
	localparam int TO_ANG_LSB = 16;
	localparam logic [15:0] TO_MS_RST = 16'h000a;
	localparam logic [31:0] TOVAL_RST = 32'h00000000;
	localparam logic [31:0] LEVEL_FULL = 32'hffffffff;
	localparam logic [31:0] LEVEL_NONE = 32'h00000000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		VPT_Q_NONE = 2'b00,
		VPT_Q_ENABLE = 2'b01,
		VPT_Q_VALIDATE = 2'b10
	} vpt_qual_e;

	typedef enum logic
	{
		VPT_IDLE = 1'b0,
		VPT_RUN = 1'b1
	} vpt_state_e;

	typedef struct packed
	{
		logic [2:0] meas_ch;
		logic [2:0] qual_ch;
		logic meas_high;
		vpt_qual_e qual;
		logic qual_act_high;
		logic to_angle;
		logic to_level;
	} vpt_cfg_s;

endpackage

// [vpt_pulse_timing.sv]
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Enable qualifier: measure only pulses lying wholly inside an active enable pulse.
// - Validate qualifier: measure only pulses wholly containing an active validate pulse.
// - Both qualifiers work for high and low times, either active level.
// - Low time is falling-to-rising interval in microseconds, taken at the rising edge.
// - High time is rising-to-falling interval in microseconds, taken at the falling edge.
// - A new result becomes visible at the next signal group time step.
// - Inputs are evaluated only at edges; results hold until new edges or timeout.
// - Each result is checked periodically; no new edge since last check means timeout.
// - Check runs every set milliseconds or once per cycle at a set angle.
// - Timeout loads a set value or a value from the present input level.
// - Level-based timeout gives the empty or the full value by input level.
// - In angle mode, below 10 rpm the engine counts as stopped and times out.
// - Each measurement has its own angle segment; edges outside it are ignored.
// - Segment limits lie anywhere in 720 degrees, wrapping past zero allowed.
// - Several measurements may share one input channel with separate segments.
// - A global enable switches all edge detection and evaluation on or off.

module vpt_pulse_timing
(
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	input wire logic [vpt_pkg::NCH-1:0] chan_in,
	input wire logic [vpt_pkg::ANG_W-1:0] crank_angle_in,
	input wire logic [15:0] engine_rpm_in,
	input wire logic step_in,
	output logic irq_out
);

	function automatic logic [7:0] slot_addr(input int idx, input logic [7:0] off);
		slot_addr = vpt_pkg::A_SLOT0 + 8'(idx * vpt_pkg::SLOT_STRIDE) + off;
	endfunction

	// Inclusive window; lo above hi means the window wraps past zero.
	function automatic logic in_window(input logic [vpt_pkg::ANG_W-1:0] a,
		input logic [vpt_pkg::ANG_W-1:0] lo, input logic [vpt_pkg::ANG_W-1:0] hi);
		if (lo <= hi)
		begin
			in_window = (a >= lo) && (a <= hi);
		end
		else
		begin
			in_window = (a >= lo) || (a <= hi);
		end
	endfunction

	// True when the angle moved past the mark since the previous sample.
	function automatic logic crossed(input logic [vpt_pkg::ANG_W-1:0] p,
		input logic [vpt_pkg::ANG_W-1:0] c, input logic [vpt_pkg::ANG_W-1:0] k);
		if (p == c)
		begin
			crossed = 1'b0;
		end
		else if (p < c)
		begin
			crossed = (k > p) && (k <= c);
		end
		else
		begin
			crossed = (k > p) || (k <= c);
		end
	endfunction

	// ----------------------------------------------------------------
	// Time base
	// ----------------------------------------------------------------
	logic [6:0] us_cnt, next_us_cnt;
	logic [9:0] ms_cnt, next_ms_cnt;
	logic [31:0] now_us, next_now_us;
	logic us_tick, ms_tick;

	always_comb
	begin
		us_tick = (us_cnt == 7'(vpt_pkg::US_CYCLES - 1));
		ms_tick = us_tick && (ms_cnt == 10'(vpt_pkg::US_PER_MS - 1));
		next_us_cnt = us_tick ? 7'h00 : us_cnt + 7'h01;
		// Free running so that a wrap between two edges still subtracts right.
		next_now_us = us_tick ? now_us + 32'h00000001 : now_us;
		next_ms_cnt = ms_cnt;
		if (ms_tick)
		begin
			next_ms_cnt = 10'h000;
		end
		else if (us_tick)
		begin
			next_ms_cnt = ms_cnt + 10'h001;
		end
	end

	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			us_cnt <= 7'h00;
			ms_cnt <= 10'h000;
			now_us <= 32'h00000000;
		end
		else
		begin
			us_cnt <= next_us_cnt;
			ms_cnt <= next_ms_cnt;
			now_us <= next_now_us;
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic ctrl_en, next_ctrl_en;
	logic [2*vpt_pkg::NSLOT-1:0] irq_en, next_irq_en;
	vpt_pkg::vpt_cfg_s cfg [vpt_pkg::NSLOT];
	vpt_pkg::vpt_cfg_s next_cfg [vpt_pkg::NSLOT];
	logic [vpt_pkg::ANG_W-1:0] seg_lo [vpt_pkg::NSLOT];
	logic [vpt_pkg::ANG_W-1:0] next_seg_lo [vpt_pkg::NSLOT];
	logic [vpt_pkg::ANG_W-1:0] seg_hi [vpt_pkg::NSLOT];
	logic [vpt_pkg::ANG_W-1:0] next_seg_hi [vpt_pkg::NSLOT];
	logic [15:0] to_ms [vpt_pkg::NSLOT];
	logic [15:0] next_to_ms [vpt_pkg::NSLOT];
	logic [vpt_pkg::ANG_W-1:0] to_ang [vpt_pkg::NSLOT];
	logic [vpt_pkg::ANG_W-1:0] next_to_ang [vpt_pkg::NSLOT];
	logic [31:0] to_val [vpt_pkg::NSLOT];
	logic [31:0] next_to_val [vpt_pkg::NSLOT];

	always_comb
	begin
		next_ctrl_en = ctrl_en;
		next_irq_en = irq_en;
		if (wr_in && addr_in == vpt_pkg::A_CTRL)
		begin
			next_ctrl_en = wdata_in[vpt_pkg::CTRL_EN_BIT];
		end
		if (wr_in && addr_in == vpt_pkg::A_IRQ_EN)
		begin
			next_irq_en = wdata_in[2*vpt_pkg::NSLOT-1:0];
		end
		for (int i = 0; i < vpt_pkg::NSLOT; i++)
		begin
			next_cfg[i] = cfg[i];
			next_seg_lo[i] = seg_lo[i];
			next_seg_hi[i] = seg_hi[i];
			next_to_ms[i] = to_ms[i];
			next_to_ang[i] = to_ang[i];
			next_to_val[i] = to_val[i];
			if (wr_in && addr_in == slot_addr(i, vpt_pkg::O_CFG))
			begin
				next_cfg[i] = vpt_pkg::vpt_cfg_s'(wdata_in[vpt_pkg::CFG_W-1:0]);
			end
			if (wr_in && addr_in == slot_addr(i, vpt_pkg::O_SEG))
			begin
				next_seg_lo[i] = wdata_in[vpt_pkg::SEG_LO_LSB +: vpt_pkg::ANG_W];
				next_seg_hi[i] = wdata_in[vpt_pkg::SEG_HI_LSB +: vpt_pkg::ANG_W];
			end
			if (wr_in && addr_in == slot_addr(i, vpt_pkg::O_TO))
			begin
				next_to_ms[i] = wdata_in[vpt_pkg::TO_MS_LSB +: 16];
				next_to_ang[i] = wdata_in[vpt_pkg::TO_ANG_LSB +: vpt_pkg::ANG_W];
			end
			if (wr_in && addr_in == slot_addr(i, vpt_pkg::O_TOVAL))
			begin
				next_to_val[i] = wdata_in;
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			ctrl_en <= 1'b0;
			irq_en <= '0;
			for (int i = 0; i < vpt_pkg::NSLOT; i++)
			begin
				cfg[i] <= '0;
				seg_lo[i] <= '0;
				seg_hi[i] <= '0;
				to_ms[i] <= vpt_pkg::TO_MS_RST;
				to_ang[i] <= '0;
				to_val[i] <= vpt_pkg::TOVAL_RST;
			end
		end
		else
		begin
			ctrl_en <= next_ctrl_en;
			irq_en <= next_irq_en;
			for (int i = 0; i < vpt_pkg::NSLOT; i++)
			begin
				cfg[i] <= next_cfg[i];
				seg_lo[i] <= next_seg_lo[i];
				seg_hi[i] <= next_seg_hi[i];
				to_ms[i] <= next_to_ms[i];
				to_ang[i] <= next_to_ang[i];
				to_val[i] <= next_to_val[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// Measurement slots
	// ----------------------------------------------------------------
	logic [vpt_pkg::NSLOT-1:0] done;
	logic [31:0] value [vpt_pkg::NSLOT];
	logic [vpt_pkg::NSLOT-1:0] level;

	generate
		for (genvar g = 0; g < vpt_pkg::NSLOT; g++)
		begin : g_slot
			// Any slot may pick any channel, so channels can be shared.
			assign level[g] = chan_in[cfg[g].meas_ch];
			vpt_slot u_slot
			(
				.core_clk_in(core_clk_in),
				.nrst_in(nrst_in),
				.en_in(ctrl_en),
				.meas_in(level[g]),
				.qual_in(chan_in[cfg[g].qual_ch]),
				.in_seg_in(in_window(crank_angle_in, seg_lo[g], seg_hi[g])),
				.now_in(now_us),
				.cfg_in(cfg[g]),
				.done_out(done[g]),
				.value_out(value[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Timeout, publication and interrupts
	// ----------------------------------------------------------------
	logic [vpt_pkg::ANG_W-1:0] ang_prev, next_ang_prev;
	logic [vpt_pkg::NSLOT-1:0] seen, next_seen;
	logic [vpt_pkg::NSLOT-1:0] pend_to, next_pend_to;
	logic [vpt_pkg::NSLOT-1:0] res_to, next_res_to;
	logic [15:0] ms_acc [vpt_pkg::NSLOT];
	logic [15:0] next_ms_acc [vpt_pkg::NSLOT];
	logic [31:0] pend_val [vpt_pkg::NSLOT];
	logic [31:0] next_pend_val [vpt_pkg::NSLOT];
	logic [31:0] res [vpt_pkg::NSLOT];
	logic [31:0] next_res [vpt_pkg::NSLOT];
	logic [2*vpt_pkg::NSLOT-1:0] irq_stat, next_irq_stat, irq_ev, irq_clr;
	logic [vpt_pkg::NSLOT-1:0] chk, tmo;
	logic stopped;

	always_comb
	begin
		stopped = engine_rpm_in < vpt_pkg::RPM_STOP;
		next_ang_prev = crank_angle_in;
		irq_clr = '0;
		if (wr_in && addr_in == vpt_pkg::A_IRQ_CLR)
		begin
			irq_clr = wdata_in[2*vpt_pkg::NSLOT-1:0];
		end
		for (int i = 0; i < vpt_pkg::NSLOT; i++)
		begin
			next_ms_acc[i] = ms_acc[i];
			next_pend_val[i] = pend_val[i];
			next_pend_to[i] = pend_to[i];
			next_res[i] = res[i];
			next_res_to[i] = res_to[i];
			chk[i] = 1'b0;
			if (ctrl_en && cfg[i].to_angle)
			begin
				chk[i] = crossed(ang_prev, crank_angle_in, to_ang[i]) | (stopped & ms_tick);
				next_ms_acc[i] = 16'h0000;
			end
			else if (ctrl_en && ms_tick)
			begin
				chk[i] = (ms_acc[i] + 16'h0001) >= to_ms[i];
				next_ms_acc[i] = chk[i] ? 16'h0000 : ms_acc[i] + 16'h0001;
			end
			// In angle mode a stopped engine times out even though edges may have been seen.
			tmo[i] = chk[i] & (~(seen[i] | done[i]) | (cfg[i].to_angle & stopped));
			// A new edge in the check cycle still counts for the next window.
			next_seen[i] = done[i] | (seen[i] & ~chk[i]);
			if (done[i])
			begin
				next_pend_val[i] = value[i];
				next_pend_to[i] = 1'b0;
			end
			else if (tmo[i])
			begin
				next_pend_to[i] = 1'b1;
				if (cfg[i].to_level)
				begin
					next_pend_val[i] = (level[i] == cfg[i].meas_high) ?
						vpt_pkg::LEVEL_FULL : vpt_pkg::LEVEL_NONE;
				end
				else
				begin
					next_pend_val[i] = to_val[i];
				end
			end
			if (step_in)
			begin
				next_res[i] = pend_val[i];
				next_res_to[i] = pend_to[i];
			end
		end
		irq_ev = {tmo, done};
		// Set wins over clear so no event is lost in the clearing cycle.
		next_irq_stat = (irq_stat & ~irq_clr) | irq_ev;
	end

	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			ang_prev <= '0;
			seen <= '0;
			pend_to <= '0;
			res_to <= '0;
			irq_stat <= '0;
			for (int i = 0; i < vpt_pkg::NSLOT; i++)
			begin
				ms_acc[i] <= 16'h0000;
				pend_val[i] <= 32'h00000000;
				res[i] <= 32'h00000000;
			end
		end
		else
		begin
			ang_prev <= next_ang_prev;
			seen <= next_seen;
			pend_to <= next_pend_to;
			res_to <= next_res_to;
			irq_stat <= next_irq_stat;
			for (int i = 0; i < vpt_pkg::NSLOT; i++)
			begin
				ms_acc[i] <= next_ms_acc[i];
				pend_val[i] <= next_pend_val[i];
				res[i] <= next_res[i];
			end
		end
	end

	assign irq_out = |(irq_stat & irq_en);

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	logic [31:0] next_rdata;

	always_comb
	begin
		next_rdata = 32'h00000000;
		if (rd_in)
		begin
			if (addr_in == vpt_pkg::A_CTRL)
			begin
				next_rdata = {31'h00000000, ctrl_en};
			end
			if (addr_in == vpt_pkg::A_IRQ_STAT)
			begin
				next_rdata = 32'(irq_stat);
			end
			if (addr_in == vpt_pkg::A_IRQ_EN)
			begin
				next_rdata = 32'(irq_en);
			end
			for (int i = 0; i < vpt_pkg::NSLOT; i++)
			begin
				if (addr_in == slot_addr(i, vpt_pkg::O_CFG))
				begin
					next_rdata = 32'(cfg[i]);
				end
				if (addr_in == slot_addr(i, vpt_pkg::O_SEG))
				begin
					next_rdata = {6'h00, seg_hi[i], 6'h00, seg_lo[i]};
				end
				if (addr_in == slot_addr(i, vpt_pkg::O_TO))
				begin
					next_rdata = {6'h00, to_ang[i], to_ms[i]};
				end
				if (addr_in == slot_addr(i, vpt_pkg::O_TOVAL))
				begin
					next_rdata = to_val[i];
				end
				if (addr_in == slot_addr(i, vpt_pkg::O_RES))
				begin
					next_rdata = res[i];
				end
				if (addr_in == slot_addr(i, vpt_pkg::O_STAT))
				begin
					next_rdata = {31'h00000000, res_to[i]};
				end
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			rdata_out <= 32'h00000000;
		end
		else
		begin
			rdata_out <= next_rdata;
		end
	end

endmodule

`default_nettype wire

// [vpt_pulse_timing_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module vpt_pulse_timing_chk
(
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [31:0] rdata_out,
	input wire logic [vpt_pkg::NCH-1:0] chan_in,
	input wire logic [vpt_pkg::ANG_W-1:0] crank_angle_in,
	input wire logic [15:0] engine_rpm_in,
	input wire logic step_in,
	input wire logic irq_out
);
	// ----
	// Shadow of bus traffic
	// ----
	localparam logic [7:0] RES0 = 8'h50;
	logic en_q, next_en, rd_q, next_rd, step_q, next_step;
	logic have_q, next_have, same_q, next_same;
	logic [7:0] ien_q, next_ien, ra_q, next_ra;
	logic [31:0] res_q, next_res;

	// A step at the read edge or the capture edge may or may not be seen, so it
	// spoils the comparison rather than risk a false failure.
	always_comb
	begin
		next_en = (wr_in && addr_in == vpt_pkg::A_CTRL) ? wdata_in[0] : en_q;
		next_ien = (wr_in && addr_in == vpt_pkg::A_IRQ_EN) ? wdata_in[7:0] : ien_q;
		next_rd = rd_in;
		next_ra = addr_in;
		next_step = step_in;
		next_res = res_q;
		next_have = have_q;
		next_same = same_q && !step_in;
		if (rd_q && ra_q == RES0)
		begin
			next_res = rdata_out;
			next_have = 1'b1;
			next_same = !step_in && !step_q;
		end
	end

	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			{en_q, rd_q, step_q, have_q, same_q, ien_q, ra_q, res_q} <= '0;
		end
		else
		begin
			{en_q, rd_q, step_q, have_q, same_q} <= {next_en, next_rd, next_step, next_have, next_same};
			{ien_q, ra_q, res_q} <= {next_ien, next_ra, next_res};
		end
	end

	// ----
	// Properties
	// ----
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!nrst_in);

	a_rdata_quiet: assert property (!rd_q |-> rdata_out == 32'h0)
		else $error("read data not zero outside a read");
	a_unmapped_zero: assert property (rd_q && ra_q == 8'h30 |-> rdata_out == 32'h0)
		else $error("unmapped read not zero");
	a_clear_reads_zero: assert property (rd_q && ra_q == vpt_pkg::A_IRQ_CLR |-> rdata_out == 32'h0)
		else $error("clear register read not zero");
	a_ctrl_readback: assert property (rd_q && ra_q == vpt_pkg::A_CTRL |-> rdata_out[0] == en_q)
		else $error("global enable readback wrong");
	a_irq_en_readback: assert property (rd_q && ra_q == vpt_pkg::A_IRQ_EN |-> rdata_out[7:0] == ien_q)
		else $error("interrupt enable readback wrong");
	a_irq_masked: assert property (ien_q == 8'h00 |-> !irq_out)
		else $error("interrupt high with all sources masked");
	a_irq_cause: assert property ($rose(irq_out) |->
		$past(wr_in) || $past(en_q) || $past(en_q, 2) || $past(en_q, 3) || $past(en_q, 4))
		else $error("interrupt rose with evaluation off");
	a_result_holds: assert property (rd_q && ra_q == RES0 && have_q && same_q |-> rdata_out == res_q)
		else $error("result changed without a time step");
endmodule
bind vpt_pulse_timing vpt_pulse_timing_chk chk_u (.core_clk_in, .nrst_in, .addr_in, .wdata_in,
	.wr_in, .rd_in, .rdata_out, .chan_in, .crank_angle_in, .engine_rpm_in, .step_in, .irq_out);
`default_nettype wire

// [vpt_slot.sv]
`timescale 1ns/1ps
`default_nettype none

module vpt_slot
(
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic en_in,
	input wire logic meas_in,
	input wire logic qual_in,
	input wire logic in_seg_in,
	input wire logic [31:0] now_in,
	input wire vpt_pkg::vpt_cfg_s cfg_in,
	output logic done_out,
	output logic [31:0] value_out
);

	vpt_pkg::vpt_state_e st, next_st;
	logic meas_d, next_meas_d;
	logic qact_d, next_qact_d;
	logic q_ok, next_q_ok;
	logic v_open, next_v_open;
	logic v_done, next_v_done;
	logic [31:0] t_start, next_t_start;
	logic next_done;
	logic [31:0] next_value;
	logic q_act, start_edge, end_edge, pass;

	always_comb
	begin
		q_act = cfg_in.qual_act_high ? qual_in : ~qual_in;
		start_edge = cfg_in.meas_high ? (meas_in & ~meas_d) : (~meas_in & meas_d);
		end_edge = cfg_in.meas_high ? (~meas_in & meas_d) : (meas_in & ~meas_d);
		next_meas_d = meas_in;
		next_qact_d = q_act;
		next_st = st;
		next_q_ok = q_ok;
		next_v_open = v_open;
		next_v_done = v_done;
		next_t_start = t_start;
		next_done = 1'b0;
		next_value = value_out;
		unique case (cfg_in.qual)
			vpt_pkg::VPT_Q_NONE: pass = 1'b1;
			vpt_pkg::VPT_Q_ENABLE: pass = q_ok & q_act;
			vpt_pkg::VPT_Q_VALIDATE: pass = v_done;
			default: pass = 1'b1;
		endcase
		if (!en_in)
		begin
			next_st = vpt_pkg::VPT_IDLE;
		end
		else
		begin
			unique case (st)
				vpt_pkg::VPT_IDLE:
				begin
					if (start_edge && in_seg_in)
					begin
						next_st = vpt_pkg::VPT_RUN;
						next_t_start = now_in;
						next_q_ok = q_act;
						next_v_open = 1'b0;
						next_v_done = 1'b0;
					end
				end
				vpt_pkg::VPT_RUN:
				begin
					next_q_ok = q_ok & q_act;
					if (q_act && !qact_d)
					begin
						next_v_open = 1'b1;
					end
					if (!q_act && qact_d && v_open)
					begin
						next_v_done = 1'b1;
					end
					if (end_edge)
					begin
						next_st = vpt_pkg::VPT_IDLE;
						// A failed pulse leaves the held value and done untouched.
						if (in_seg_in && pass)
						begin
							next_done = 1'b1;
							next_value = now_in - t_start;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			st <= vpt_pkg::VPT_IDLE;
			meas_d <= 1'b0;
			qact_d <= 1'b0;
			q_ok <= 1'b0;
			v_open <= 1'b0;
			v_done <= 1'b0;
			t_start <= 32'h00000000;
			done_out <= 1'b0;
			value_out <= 32'h00000000;
		end
		else
		begin
			st <= next_st;
			meas_d <= next_meas_d;
			qact_d <= next_qact_d;
			q_ok <= next_q_ok;
			v_open <= next_v_open;
			v_done <= next_v_done;
			t_start <= next_t_start;
			done_out <= next_done;
			value_out <= next_value;
		end
	end

endmodule

`default_nettype wire

// [vpt_unit_model.sv]
`timescale 1ns/1ps
`default_nettype none
module vpt_unit_model
(
	input wire logic core_clk_in,
	output logic [vpt_pkg::NCH-1:0] chan_out
);
	// Measured lines 0 and 1 and validate line 4 idle high, measured line 2 idles low, so the first fall on line 0 opens a low pulse.
	initial chan_out = 8'h13;

	task automatic hold(input logic [vpt_pkg::NCH-1:0] lvl, input int cyc);
		@(posedge core_clk_in);
		chan_out <= lvl;
		repeat (cyc - 1) @(posedge core_clk_in);
	endtask
endmodule
`default_nettype wire
